// ===== src/irss_device.sv
// serial register slave with bus-paced led self-test
// Operation
// - sda changes only while scl is low
// - sda fall with scl high starts session
// - sda rise with scl high ends session
// - only the master makes start and stop
// - bus busy from start until stop
// - repeated start restarts address reception
// - eight bits msb first, then ack slot
// - receiver pulls sda low on ninth clock
// - addressed receiver acknowledges every byte
// - first seven bits address, eighth is direction
// - direction zero writes, one reads
// - write: index byte, then data byte
// - master writes index before reading
// - writing 01h to 0Ch starts self-test
// - next transaction reads back self-test result
// - host enables standby and boost first
// - self-test steps paced by scl, slow clock
`timescale 1ns/1ps
`include "irss_consts.svh"
module irss_device (
  // clock, reset, enable
  input  wire logic                I_CLOCK,
  input  wire logic                I_SRST,
  input  wire logic                I_CE,
  // serial link
  irss_if.dev                      bus,
  // self-test probes, one per led path
  input  wire logic [3:0]          I_LED_OK,
  // register write notice
  output logic                     O_REG_WR,
  output logic [7:0]               O_REG_INDEX,
  output logic [7:0]               O_REG_DATA,
  // status
  output logic                     O_BUS_BUSY,
  output logic                     O_SELFTEST_BUSY,
  output logic [1:0]               O_SELFTEST_STEP
);
  import irss_pkg::*;

  irss_dev_t r;
  irss_dev_t n;
  logic      scl_rise;
  logic      scl_fall;
  logic      start_cond;
  logic      stop_cond;

  // ****************************************
  // read data selection
  // ****************************************
  function automatic logic [7:0] rd_byte(input irss_dev_t s,
                                         input logic [7:0] i);
    logic [7:0] v;
    v = 8'h00;
    if (i < 8'(`IRSS_NUM_REGS)) begin
      v = s.regs[i[`IRSS_IDX_W-1:0]];
    end
    // pending result replaces the stored byte
    if (i == `IRSS_REG_SELFTEST && s.st_pend) begin
      v = {~s.st_run, 3'h0, s.st_res};
    end
    return v;
  endfunction : rd_byte

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    n = r;
    n.wr_stb = 1'b0;
    // only the second stage of each synchroniser and, for scl and sda, its delayed copy are looked at
    n.scl_s1 = bus.scl;
    n.scl_s2 = r.scl_s1;
    n.scl_d  = r.scl_s2;
    n.sda_s1 = bus.sda;
    n.sda_s2 = r.sda_s1;
    n.sda_d  = r.sda_s2;
    n.led_s1 = I_LED_OK;
    n.led_s2 = r.led_s1;

    scl_rise   = r.scl_s2 & ~r.scl_d;
    scl_fall   = ~r.scl_s2 & r.scl_d;
    // high-to-low on sda while scl stays high
    start_cond = r.scl_s2 & r.scl_d & r.sda_d & ~r.sda_s2;
    // low-to-high on sda while scl stays high
    stop_cond  = r.scl_s2 & r.scl_d & ~r.sda_d & r.sda_s2;

    // one probe per scl rise; a fast clock gives short settling
    if (r.st_run && scl_rise) begin
      n.st_res[r.st_step] = r.led_s2[r.st_step];
      n.st_step = r.st_step + 2'h1;
      if (r.st_step == 2'(`IRSS_SELFTEST_STEPS - 1)) begin
        n.st_run = 1'b0;
      end
    end

    if (start_cond) begin
      // repeated start treated as a fresh one
      n.st      = S_ADDR;
      n.cnt     = 4'h0;
      n.ack     = 1'b0;
      n.sda_low = 1'b0;
      n.busy    = 1'b1;
    end else if (stop_cond) begin
      n.st      = S_IDLE;
      n.busy    = 1'b0;
      n.sda_low = 1'b0;
      n.ack     = 1'b0;
      // the result survives one transaction holding a read
      if (r.rd_seen) begin
        n.st_pend = 1'b0;
      end
      n.rd_seen = 1'b0;
    end else begin
      unique case (r.st)
        S_IDLE, S_IGNORE: begin
          n.sda_low = 1'b0;
        end
        S_ADDR, S_INDEX, S_WDATA: begin
          if (scl_rise && !r.ack) begin
            n.sh  = {r.sh[6:0], r.sda_s2};
            n.cnt = r.cnt + 4'h1;
          end
          // drive changes only on scl fall
          if (scl_fall && !r.ack && r.cnt == `IRSS_BYTE_BITS) begin
            n.ack = 1'b1;
            unique case (r.st)
              S_ADDR: begin
                if (r.sh[7:1] == `IRSS_DEV_ADDR) begin
                  // pull low through the ninth clock
                  n.sda_low = 1'b1;
                  n.rw      = r.sh[0];
                end else begin
                  n.st  = S_IGNORE;
                  n.ack = 1'b0;
                end
              end
              S_INDEX: begin
                n.sda_low = 1'b1;
                n.idx     = r.sh;
              end
              default: begin
                n.sda_low = 1'b1;
                n.wr_stb  = 1'b1;
                // third byte stored at the index
                if (r.idx < 8'(`IRSS_NUM_REGS)) begin
                  n.regs[r.idx[`IRSS_IDX_W-1:0]] = r.sh;
                end
                if (r.idx == `IRSS_REG_SELFTEST &&
                    r.sh == `IRSS_SELFTEST_GO) begin
                  n.st_run  = 1'b1;
                  n.st_pend = 1'b1;
                  n.st_step = 2'h0;
                  n.st_res  = 4'h0;
                end
              end
            endcase
          end else if (scl_fall && r.ack) begin
            // end of ack slot, release and move on
            n.ack     = 1'b0;
            n.sda_low = 1'b0;
            n.cnt     = 4'h0;
            unique case (r.st)
              S_ADDR: begin
                if (r.rw == `IRSS_DIR_READ) begin
                  // read uses the index written before
                  n.st      = S_TX;
                  n.sh      = rd_byte(r, r.idx);
                  n.sda_low = ~n.sh[7];
                  n.rd_seen = 1'b1;
                end else begin
                  n.st = S_INDEX;
                end
              end
              S_INDEX: begin
                n.st = S_WDATA;
              end
              default: begin
                // further bytes land at following indexes
                n.idx = r.idx + 8'h01;
              end
            endcase
          end
        end
        S_TX: begin
          if (scl_rise) begin
            if (!r.ack) begin
              n.cnt = r.cnt + 4'h1;
            end else if (r.sda_s2) begin
              n.st = S_IGNORE;
            end
          end
          if (scl_fall && !r.ack) begin
            if (r.cnt == `IRSS_BYTE_BITS) begin
              // transmitter releases during the ack clock
              n.sda_low = 1'b0;
              n.ack     = 1'b1;
            end else begin
              // next bit set up while scl is low
              n.sh      = {r.sh[6:0], 1'b0};
              n.sda_low = ~r.sh[6];
            end
          end else if (scl_fall && r.ack) begin
            n.ack     = 1'b0;
            n.cnt     = 4'h0;
            n.idx     = r.idx + 8'h01;
            n.sh      = rd_byte(r, r.idx + 8'h01);
            n.sda_low = ~n.sh[7];
          end
        end
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      r <= '0;
    end else if (I_CE) begin
      r <= n;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // open drain: only ever pulls low
  assign bus.dev_sda_o    = 1'b0;
  assign bus.dev_sda_oe   = r.sda_low;
  assign O_REG_WR         = r.wr_stb;
  assign O_REG_INDEX      = r.idx;
  assign O_REG_DATA       = r.sh;
  assign O_BUS_BUSY       = r.busy;
  assign O_SELFTEST_BUSY  = r.st_run;
  assign O_SELFTEST_STEP  = r.st_step;

endmodule : irss_device

// ===== include/irss_consts.svh
// constants of the serial register slave, its master and the self-test
`ifndef IRSS_CONSTS_SVH
`define IRSS_CONSTS_SVH

// ****************************************
// bus addressing
// ****************************************
`define IRSS_DEV_ADDR        7'h4C
`define IRSS_DIR_WRITE       1'b0
`define IRSS_DIR_READ        1'b1
`define IRSS_BYTE_BITS       4'h8
`define IRSS_NUM_REGS        16
`define IRSS_IDX_W           4

// ****************************************
// register map
// ****************************************
`define IRSS_REG_SELFTEST    8'h0C
`define IRSS_SELFTEST_GO     8'h01
`define IRSS_REG_ENABLE      8'h10
`define IRSS_EN_STANDBY_BIT  6
`define IRSS_EN_BOOST_BIT    5
`define IRSS_RESULT_DONE_BIT 7
`define IRSS_SELFTEST_STEPS  4

// ****************************************
// serial clock timing
// ****************************************
`define IRSS_CLK_MHZ         250
`define IRSS_FAST_KHZ        400
`define IRSS_SLOW_KHZ        50
`define IRSS_QTR_FAST \
  ((`IRSS_CLK_MHZ * 1000 + 4 * `IRSS_FAST_KHZ - 1) / (4 * `IRSS_FAST_KHZ))
`define IRSS_QTR_SLOW \
  ((`IRSS_CLK_MHZ * 1000 + 4 * `IRSS_SLOW_KHZ - 1) / (4 * `IRSS_SLOW_KHZ))

`endif

// ===== include/irss_pkg.sv
// types shared by the serial register slave and its master
package irss_pkg;

  // ****************************************
  // slave side
  // ****************************************
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_INDEX, S_WDATA, S_TX, S_IGNORE
  } irss_dev_state_t;

  typedef struct packed {
    logic              scl_s1;
    logic              scl_s2;
    logic              scl_d;
    logic              sda_s1;
    logic              sda_s2;
    logic              sda_d;
    logic [3:0]        led_s1;
    logic [3:0]        led_s2;
    irss_dev_state_t   st;
    logic [3:0]        cnt;
    logic              ack;
    logic              rw;
    logic [7:0]        sh;
    logic [7:0]        idx;
    logic              sda_low;
    logic              busy;
    logic              wr_stb;
    logic              rd_seen;
    logic              st_run;
    logic              st_pend;
    logic [1:0]        st_step;
    logic [3:0]        st_res;
    logic [15:0][7:0]  regs;
  } irss_dev_t;

  // ****************************************
  // master side
  // ****************************************
  typedef enum logic [1:0] {
    H_IDLE, H_START, H_BYTE, H_STOP
  } irss_host_state_t;

  typedef struct packed {
    logic              sda_s1;
    logic              sda_s2;
    irss_host_state_t  st;
    logic [11:0]       div;
    logic [1:0]        q;
    logic              scl_low;
    logic              sda_low;
    logic              rw;
    logic [7:0]        idx;
    logic [7:0]        data;
    logic [1:0]        bytei;
    logic [3:0]        bitn;
    logic [7:0]        sh;
    logic [7:0]        rx;
    logic [7:0]        rdata;
    logic              nack;
    logic              done;
    logic              refused;
    logic              slow;
    logic              en_ok;
  } irss_host_t;

endpackage : irss_pkg

// ===== include/irss_if.sv
// two-wire link between master and slave, sda resolved with pull-up
`timescale 1ns/1ps
interface irss_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;

  // open drain: any enabled low driver wins, else pulled high
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport host (output scl, output host_sda_o, output host_sda_oe,
                input sda);
  modport dev  (input scl, input sda, output dev_sda_o,
                output dev_sda_oe);
endinterface : irss_if

// ===== src/irss_host.sv
// bus master issuing register writes and index-then-read transfers
`timescale 1ns/1ps
`include "irss_consts.svh"
module irss_host (
  // clock, reset, enable
  input  wire logic                I_CLOCK,
  input  wire logic                I_SRST,
  input  wire logic                I_CE,
  // serial link
  irss_if.host                     bus,
  // command port
  input  wire logic                I_CMD_VALID,
  input  wire logic                I_CMD_READ,
  input  wire logic [7:0]          I_CMD_INDEX,
  input  wire logic [7:0]          I_CMD_DATA,
  output logic                     O_CMD_READY,
  // completion
  output logic                     O_DONE,
  output logic                     O_NACK,
  output logic                     O_REFUSED,
  output logic [7:0]               O_RDATA,
  output logic                     O_SLOW
);
  import irss_pkg::*;

  irss_host_t r;
  irss_host_t n;
  logic       tick;
  logic       rx_byte;
  logic       launch;
  logic [11:0] qtr;

  // ****************************************
  // byte sequence of one transfer
  // ****************************************
  function automatic logic [7:0] tx_byte(input irss_host_t s,
                                         input logic [1:0] b);
    logic [7:0] v;
    v = {`IRSS_DEV_ADDR, `IRSS_DIR_WRITE};
    if (b == 2'h1) begin
      v = s.idx;
    end else if (b == 2'h2) begin
      v = s.rw ? {`IRSS_DEV_ADDR, `IRSS_DIR_READ} : s.data;
    end else if (b == 2'h3) begin
      v = 8'hFF;
    end
    return v;
  endfunction : tx_byte

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    n = r;
    n.done    = 1'b0;
    n.refused = 1'b0;
    n.sda_s1  = bus.sda;
    n.sda_s2  = r.sda_s1;
    // slow clock for the whole self-test session
    qtr     = r.slow ? 12'(`IRSS_QTR_SLOW) : 12'(`IRSS_QTR_FAST);
    tick    = (r.div == 12'h000);
    rx_byte = (r.bytei == 2'h3);
    launch  = !I_CMD_READ && I_CMD_INDEX == `IRSS_REG_SELFTEST &&
              I_CMD_DATA == `IRSS_SELFTEST_GO;

    if (r.st == H_IDLE) begin
      if (I_CMD_VALID) begin
        // no launch before standby and boost are enabled
        if (launch && !r.en_ok) begin
          n.refused = 1'b1;
        end else begin
          n.st    = H_START;
          n.q     = 2'h0;
          n.div   = qtr;
          n.rw    = I_CMD_READ;
          n.idx   = I_CMD_INDEX;
          n.data  = I_CMD_DATA;
          n.bytei = 2'h0;
          n.nack  = 1'b0;
          n.rx    = 8'h00;
          if (launch) begin
            n.slow = 1'b1;
            n.div  = 12'(`IRSS_QTR_SLOW);
          end
        end
      end
    end else if (!tick) begin
      n.div = r.div - 12'h001;
    end else begin
      n.div = qtr - 12'h001;
      n.q   = r.q + 2'h1;
      unique case (r.st)
        H_START: begin
          // start or repeated start made here
          unique case (r.q)
            2'h0: n.sda_low = 1'b0;
            2'h1: n.scl_low = 1'b0;
            2'h2: n.sda_low = 1'b1;
            2'h3: begin
              n.scl_low = 1'b1;
              n.st      = H_BYTE;
              n.bitn    = 4'h0;
              n.sh      = tx_byte(r, r.bytei);
            end
          endcase
        end
        H_BYTE: begin
          unique case (r.q)
            // data set while scl is low
            2'h0: n.sda_low = (r.bitn < `IRSS_BYTE_BITS) && !rx_byte &&
                              !r.sh[7];
            2'h1: n.scl_low = 1'b0;
            2'h2: begin
              if (r.bitn < `IRSS_BYTE_BITS) begin
                n.rx = {r.rx[6:0], r.sda_s2};
              end else begin
                // slave must ack each written byte
                n.nack = r.sda_s2 && !rx_byte;
              end
            end
            2'h3: begin
              n.scl_low = 1'b1;
              if (r.bitn < `IRSS_BYTE_BITS) begin
                n.sh   = {r.sh[6:0], 1'b1};
                n.bitn = r.bitn + 4'h1;
              end else begin
                n.bitn = 4'h0;
                if (r.nack || rx_byte ||
                    (r.bytei == 2'h2 && !r.rw)) begin
                  // slave nack, the nacked read byte or the written data byte, then stop
                  n.st = H_STOP;
                end else if (r.bytei == 2'h1 && r.rw) begin
                  // index written, repeated start to read
                  n.st    = H_START;
                  n.bytei = 2'h2;
                end else begin
                  n.bytei = r.bytei + 2'h1;
                  n.sh    = tx_byte(r, r.bytei + 2'h1);
                end
              end
            end
          endcase
        end
        H_STOP: begin
          unique case (r.q)
            2'h0: n.sda_low = 1'b1;
            2'h1: n.scl_low = 1'b0;
            2'h2: n.sda_low = 1'b0;
            2'h3: begin
              // last quarter gives bus free time
              n.st   = H_IDLE;
              n.done = 1'b1;
              if (r.rw && !r.nack) begin
                n.rdata = r.rx;
              end
              if (r.rw && r.idx == `IRSS_REG_SELFTEST) begin
                n.slow = 1'b0;
              end
              if (!r.rw && !r.nack && r.idx == `IRSS_REG_ENABLE) begin
                n.en_ok = r.data[`IRSS_EN_STANDBY_BIT] &
                          r.data[`IRSS_EN_BOOST_BIT];
              end
            end
          endcase
        end
        default: begin
          n.st = H_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      r <= '0;
    end else if (I_CE) begin
      r <= n;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign bus.scl         = ~r.scl_low;
  assign bus.host_sda_o  = 1'b0;
  assign bus.host_sda_oe = r.sda_low;
  assign O_CMD_READY     = (r.st == H_IDLE);
  assign O_DONE          = r.done;
  assign O_NACK          = r.nack;
  assign O_REFUSED       = r.refused;
  assign O_RDATA         = r.rdata;
  assign O_SLOW          = r.slow;

endmodule : irss_host

// ===== verif/irss_chk.sv
// assertions on the two-wire link between master and slave
`timescale 1ns/1ps
module irss_chk (
  // clock and reset
  input  wire logic I_CLOCK,
  input  wire logic I_SRST,
  // link signals
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic host_sda_oe,
  input  wire logic dev_sda_oe
);
  // ****************************************
  // bit and byte tracking
  // ****************************************
  logic       scl_d;
  logic       sda_d;
  logic [3:0] cnt;
  logic [2:0] byten;
  logic [7:0] sh;
  logic       rd;
  wire        rise_c  = scl & ~scl_d;
  wire        start_c = scl & scl_d & sda_d & ~sda;
  wire        ack_c   = rise_c & (cnt == 4'h8);
  wire        data_c  = ack_c & (byten != 3'h0);

  // repeated start clears the count, so address reception restarts
  always_ff @(posedge I_CLOCK) begin
    scl_d <= scl;
    sda_d <= sda;
    if (I_SRST || start_c) begin
      cnt   <= 4'h0;
      byten <= 3'h0;
    end else if (ack_c) begin
      cnt   <= 4'h0;
      byten <= byten + 3'h1;
      if (byten == 3'h0) begin
        rd <= sh[0];
      end
    end else if (rise_c) begin
      cnt <= cnt + 4'h1;
      sh  <= {sh[6:0], sda};
    end
  end

  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_SRST);

  dev_sda_edge_a : assert property (
    $changed(dev_sda_oe) |-> !scl && !$past(scl))
    else $error("slave moved sda while scl high");
  sda_high_hold_a : assert property (
    rise_c |-> ##1 $stable(sda) [*8])
    else $error("sda moved right after scl rise");
  start_by_host_a : assert property (
    start_c |-> host_sda_oe && !dev_sda_oe)
    else $error("start not made by master");
  addr_ack_a : assert property (
    ack_c && byten == 3'h0 |-> dev_sda_oe == (sh[7:1] == 7'h4C))
    else $error("address ack does not match own address");
  write_ack_a : assert property (
    data_c && !rd |-> dev_sda_oe)
    else $error("written byte not acknowledged");
  read_release_a : assert property (
    data_c && rd |-> !dev_sda_oe)
    else $error("slave held sda in read ack slot");
  host_nack_a : assert property (
    data_c && rd |-> !host_sda_oe)
    else $error("master acked the single read byte");
  ack_hold_a : assert property (
    ack_c && dev_sda_oe |-> dev_sda_oe [*8])
    else $error("ack dropped early in ninth clock");
endmodule : irss_chk

// ===== verif/test_i2c_register_slave_selftest.sv
// self-checking bench: master and slave joined over the two-wire link
`timescale 1ns/1ps
`include "irss_consts.svh"
module test_i2c_register_slave_selftest;
  // ****************************************
  // signals
  // ****************************************
  logic       clk;
  logic       srst;
  logic       cmd_valid;
  logic       cmd_read;
  logic [7:0] cmd_index;
  logic [7:0] cmd_data;
  logic [3:0] led_ok;
  logic       cmd_ready, done, nack, refused, slow;
  logic       reg_wr, bus_busy, st_busy, busy_seen;
  logic [7:0] rdata, reg_index, reg_data, wr_idx, wr_dat;
  logic [1:0] st_step;
  int         failures, samples_checked, cycles, wr_cnt;

  irss_if link();
  irss_host irss_host_inst (.I_CLOCK(clk), .I_SRST(srst), .I_CE(1'b1),
    .bus(link), .I_CMD_VALID(cmd_valid), .I_CMD_READ(cmd_read),
    .I_CMD_INDEX(cmd_index), .I_CMD_DATA(cmd_data), .O_CMD_READY(cmd_ready),
    .O_DONE(done), .O_NACK(nack), .O_REFUSED(refused), .O_RDATA(rdata),
    .O_SLOW(slow));
  irss_device irss_device_inst (.I_CLOCK(clk), .I_SRST(srst), .I_CE(1'b1),
    .bus(link), .I_LED_OK(led_ok), .O_REG_WR(reg_wr),
    .O_REG_INDEX(reg_index), .O_REG_DATA(reg_data), .O_BUS_BUSY(bus_busy),
    .O_SELFTEST_BUSY(st_busy), .O_SELFTEST_STEP(st_step));
  irss_chk irss_chk_inst (.I_CLOCK(clk), .I_SRST(srst), .scl(link.scl),
    .sda(link.sda), .host_sda_oe(link.host_sda_oe),
    .dev_sda_oe(link.dev_sda_oe));

  always #2 clk = ~clk;

  // ****************************************
  // monitor and hang guard
  // ****************************************
  // slow self-test pacing makes the run long, hence the high ceiling
  always @(posedge clk) begin
    cycles++;
    if (reg_wr === 1'b1) begin
      wr_cnt++;
      wr_idx = reg_index;
      wr_dat = reg_data;
    end
    if (bus_busy === 1'b1) begin
      busy_seen = 1'b1;
    end
    if (cycles >= 700000) begin
      failures++;
      wrap_up();
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  task automatic check_bit(input logic got, input logic exp,
                           input string what);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask : check_bit

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp,
                            input string what);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check_byte

  task automatic issue(input logic rd, input logic [7:0] idx,
                       input logic [7:0] dat);
    int n;
    n = 0;
    busy_seen = 1'b0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_read  <= rd;
    cmd_index <= idx;
    cmd_data  <= dat;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
    while (done !== 1'b1 && refused !== 1'b1 && n < 400000) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : issue

  task automatic idle_bus();
    check_bit(bus_busy, 1'b0, "busy after stop");
    check_bit(link.scl, 1'b1, "scl idle");
    check_bit(link.sda, 1'b1, "sda idle");
  endtask : idle_bus

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    check_bit(cmd_ready, 1'b1, "ready after reset");
    check_byte(rdata, 8'h00, "read data after reset");
    idle_bus();
  endtask : t_reset

  task automatic t_write();
    issue(1'b0, 8'h03, 8'hA5);
    check_byte(8'(wr_cnt), 8'h01, "write pulses");
    check_byte(wr_idx, 8'h03, "write index");
    check_byte(wr_dat, 8'hA5, "write data");
    check_bit(nack, 1'b0, "write acked");
    check_bit(busy_seen, 1'b1, "busy in session");
    idle_bus();
    issue(1'b0, 8'h04, 8'h3C);
    check_byte(wr_idx, 8'h04, "second index");
    check_byte(wr_dat, 8'h3C, "second data");
  endtask : t_write

  task automatic t_read();
    issue(1'b1, 8'h03, 8'h00);
    check_byte(rdata, 8'hA5, "read back");
    check_bit(nack, 1'b0, "read acked");
    issue(1'b1, 8'h04, 8'h00);
    check_byte(rdata, 8'h3C, "read back second");
    issue(1'b1, 8'h1F, 8'h00);
    check_byte(rdata, 8'h00, "unmapped index");
    check_byte(8'(wr_cnt), 8'h02, "no pulse on reads");
    idle_bus();
  endtask : t_read

  task automatic t_refused();
    issue(1'b0, `IRSS_REG_SELFTEST, `IRSS_SELFTEST_GO);
    check_bit(refused, 1'b1, "launch refused");
    check_bit(busy_seen, 1'b0, "no session");
    check_byte(8'(wr_cnt), 8'h02, "nothing written");
  endtask : t_refused

  task automatic t_selftest();
    logic [7:0] en;
    en = (8'h01 << `IRSS_EN_STANDBY_BIT) | (8'h01 << `IRSS_EN_BOOST_BIT);
    issue(1'b0, `IRSS_REG_ENABLE, en);
    check_byte(wr_dat, en, "enable stored");
    issue(1'b0, `IRSS_REG_SELFTEST, `IRSS_SELFTEST_GO);
    check_bit(refused, 1'b0, "launch taken");
    check_bit(slow, 1'b1, "slow pacing");
    issue(1'b1, `IRSS_REG_SELFTEST, 8'h00);
    check_byte(rdata, {1'b1, 3'b000, 4'hA}, "self-test result");
    check_bit(slow, 1'b0, "pacing back to fast");
    check_bit(st_busy, 1'b0, "self-test finished");
  endtask : t_selftest

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_index = 8'h00;
    cmd_data = 8'h00;
    led_ok = 4'hA;
    failures = 0;
    samples_checked = 0;
    cycles = 0;
    wr_cnt = 0;
    busy_seen = 1'b0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_write();
    t_read();
    t_refused();
    t_selftest();
    wrap_up();
  end
endmodule : test_i2c_register_slave_selftest
